// ===== tb/cssel_src_model.sv
// Model of the on-chip event sources
`timescale 1ns/10ps
`default_nettype none
module cssel_src (
  input wire logic fire,
  input wire logic [4:0] code,
  output logic [31:0] v
);
  // Unused codes raise every line
  wire r = code == 5'h00 || code[4:2] == 3'h5 || (code > 5'h04 && code < 5'h0a);
  assign v = !fire ? 32'h0 : r ? 32'hffffffff : 32'h1 << code;
endmodule
`default_nettype wire

// ===== tb/cssel_top_monitor.sv
// Checker for the sync source selector
`timescale 1ns/10ps
`default_nettype none
module cssel_mon (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [4:0] sync_source_select,
  input wire logic sync_source_load,
  input wire logic channel_enable,
  input wire logic secondary_compare_match,
  input wire logic [4:0] sync_select_current,
  input wire logic sync_trigger_pulse,
  input wire logic trigger_out
);
  wire [4:0] c = sync_select_current;
  wire dead = c == 5'h00 || c[4:2] == 3'h5 || (c > 5'h04 && c < 5'h0a);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  AST_PW: assert property (sync_trigger_pulse |=> !sync_trigger_pulse)
    else $error("long pulse");
  AST_TO: assert property (trigger_out |=> !trigger_out)
    else $error("long trigger out");
  AST_TOC: assert property ($fell(channel_enable) |=> trigger_out)
    else $error("no trigger out");
  AST_TOF: assert property (trigger_out |-> $past(channel_enable, 2) && !$past(channel_enable))
    else $error("stray trigger out");
  AST_SEL: assert property ($past(sync_source_load, 2) && $past(rst_n, 2)
    |-> c == $past(sync_source_select, 2))
    else $error("select not stored");
  AST_HLD: assert property (!$past(sync_source_load, 2) |-> $stable(c))
    else $error("select moved");
  AST_DEAD: assert property (dead |-> !sync_trigger_pulse)
    else $error("pulse from no source");
  AST_OWN: assert property ($rose(secondary_compare_match) && c == 5'h1f
    |-> ##[1:3] sync_trigger_pulse)
    else $error("no own match pulse");
  cover property (sync_trigger_pulse && c == 5'h1f);
  cover property (trigger_out);
  cover property (dead ##1 c == 5'h0b);
endmodule
`default_nettype wire

// ===== tb/cssel_top_tb_top.sv
// Testbench for the sync source selector
`timescale 1ns/10ps
`default_nettype none
module cssel_top_tb_top;
  logic ref_clk = 0, rst_n = 0, ld = 0, en = 0, fire = 0;
  logic [4:0] sel = 5'h00;
  logic [31:0] v;
  wire [4:0] cur;
  wire pulse, tout;
  int n_fail = 0, comparisons = 0;
  always #10 ref_clk = ~ref_clk;
  cssel_src i_src (.fire(fire), .code(sel), .v(v));
  cssel_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .sync_source_select(sel),
    .sync_source_load(ld), .channel_enable(en), .secondary_compare_match(v[31]),
    .ext_irq_pin_one(v[29]), .ext_irq_pin_two(v[30]), .charge_time_unit(v[28]),
    .adc_event(v[27]), .comparator_one(v[24]), .comparator_two(v[25]),
    .comparator_three(v[26]), .capture_channel_event(v[19:16]), .timer_event(v[15:11]),
    .trigger_gen_output({{3{~fire}}, v[10]}), .other_compare_channel(v[4:1]),
    .sync_select_current(cur), .sync_trigger_pulse(pulse), .trigger_out(tout));
  task chk(input string s, input logic [4:0] g, input logic [4:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task report_and_stop;
    if (n_fail == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task t_sweep;
    int k;
    logic [4:0] n;
    logic ok;
    for (k = 0; k < 32; k++)
    begin
      if (k == 1)
        continue;
      ok = !(k == 0 || (k > 4 && k < 10) || (k > 19 && k < 24));
      sel <= k[4:0];
      ld <= 1;
      cyc(1);
      ld <= 0;
      cyc(5);
      chk("select", cur, k[4:0]);
      fire <= 1;
      n = 5'h00;
      repeat (10)
      begin
        cyc(1);
        #1 n += pulse;
      end
      cyc(1);
      fire <= 0;
      cyc(6);
      chk("pulses", n[4:0], {4'h0, ok});
    end
  endtask
  task t_off;
    logic [4:0] n;
    n = 5'h00;
    en <= 0;
    repeat (4)
    begin
      cyc(1);
      #1 n += tout;
    end
    chk("trigger_out", n[4:0], 5'h01);
  endtask
  initial
  begin
    cyc(8);
    rst_n <= 1;
    en <= 1;
    cyc(2);
    chk("default", cur, 5'h0c);
    t_sweep;
    t_off;
    report_and_stop;
  end
endmodule
bind cssel_top cssel_mon i_mon (.ref_clk(ref_clk), .rst_n(rst_n),
  .sync_source_select(sync_source_select), .sync_source_load(sync_source_load),
  .channel_enable(channel_enable), .secondary_compare_match(secondary_compare_match),
  .sync_select_current(sync_select_current), .sync_trigger_pulse(sync_trigger_pulse),
  .trigger_out(trigger_out));
`default_nettype wire

// ===== verilog/cssel_consts.vh
// Constants for the compare channel sync source selector
`ifndef CSSEL_CONSTS_VH
`define CSSEL_CONSTS_VH
`define CSSEL_SEL_W 5
`define CSSEL_SEL_LSB 0
`define CSSEL_SEL_RESET 5'h0c
`define CSSEL_SRC_NONE 5'h00
`define CSSEL_SRC_OC1 5'h01
`define CSSEL_SRC_OC2 5'h02
`define CSSEL_SRC_OC3 5'h03
`define CSSEL_SRC_OC4 5'h04
`define CSSEL_SRC_TRIG_GEN 5'h0a
`define CSSEL_SRC_TMR1 5'h0b
`define CSSEL_SRC_TMR2 5'h0c
`define CSSEL_SRC_TMR3 5'h0d
`define CSSEL_SRC_TMR4 5'h0e
`define CSSEL_SRC_TMR5 5'h0f
`define CSSEL_SRC_CAP1 5'h10
`define CSSEL_SRC_CAP2 5'h11
`define CSSEL_SRC_CAP3 5'h12
`define CSSEL_SRC_CAP4 5'h13
`define CSSEL_SRC_COMPARATOR_ONE 5'h18
`define CSSEL_SRC_COMPARATOR_TWO 5'h19
`define CSSEL_SRC_COMPARATOR_THREE 5'h1a
`define CSSEL_SRC_ADC 5'h1b
`define CSSEL_SRC_CTU 5'h1c
`define CSSEL_SRC_IRQ1 5'h1d
`define CSSEL_SRC_IRQ2 5'h1e
`define CSSEL_SRC_OWN 5'h1f
`define CSSEL_CHAN_INDEX 2'h0
`endif

// ===== verilog/cssel_sync2.v
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module cssel_sync2 #(
  parameter W = 16
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta;
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== verilog/cssel_top.v
// Sync/trigger source selector for one output compare channel
`timescale 1ns/10ps
`default_nettype none
`include "cssel_consts.vh"
module cssel_top #(
  parameter [1:0] CHAN_INDEX = `CSSEL_CHAN_INDEX
) (
  input wire ref_clk,
  input wire rst_n,
  input wire [4:0] sync_source_select,
  input wire sync_source_load,
  input wire channel_enable,
  input wire secondary_compare_match,
  input wire ext_irq_pin_one,
  input wire ext_irq_pin_two,
  input wire charge_time_unit,
  input wire adc_event,
  input wire comparator_one,
  input wire comparator_two,
  input wire comparator_three,
  input wire [3:0] capture_channel_event,
  input wire [4:0] timer_event,
  input wire [3:0] trigger_gen_output,
  input wire [3:0] other_compare_channel,
  output reg [4:0] sync_select_current,
  output reg sync_trigger_pulse,
  output reg trigger_out
);
  // Positions of the synchronised lines
  localparam [3:0] SYN_TMR1 = 4'h0;
  localparam [3:0] SYN_TMR2 = 4'h1;
  localparam [3:0] SYN_TMR3 = 4'h2;
  localparam [3:0] SYN_TMR4 = 4'h3;
  localparam [3:0] SYN_TMR5 = 4'h4;
  localparam [3:0] SYN_CAP1 = 4'h5;
  localparam [3:0] SYN_CAP4 = 4'h8;
  localparam [3:0] SYN_COMPARATOR_ONE = 4'h9;
  localparam [3:0] SYN_COMPARATOR_TWO = 4'ha;
  localparam [3:0] SYN_COMPARATOR_THREE = 4'hb;
  localparam [3:0] SYN_ADC = 4'hc;
  localparam [3:0] SYN_CTU = 4'hd;
  localparam [3:0] SYN_IRQ1 = 4'he;
  localparam [3:0] SYN_IRQ2 = 4'hf;

  wire [15:0] raw_src;
  wire [15:0] syn_src;
  reg [4:0] sel;
  reg [4:0] next_sel;
  reg prev_level;
  reg enable_d;
  reg next_level;
  reg next_pulse;
  reg next_trigger_out;

  // Capture code to synchronised line
  function [3:0] cssel_cap_line;
    input [1:0] code_low;
    begin
      cssel_cap_line = SYN_CAP1 + {2'h0, code_low};
    end
  endfunction

  // Compare code to other-channel line
  function [1:0] cssel_oc_line;
    input [1:0] code_low;
    begin
      cssel_oc_line = code_low - 2'h1;
    end
  endfunction

  // Pins and foreign events
  assign raw_src[SYN_IRQ2] = ext_irq_pin_two;
  assign raw_src[SYN_IRQ1] = ext_irq_pin_one;
  assign raw_src[SYN_CTU] = charge_time_unit;
  assign raw_src[SYN_ADC] = adc_event;
  assign raw_src[SYN_COMPARATOR_THREE] = comparator_three;
  assign raw_src[SYN_COMPARATOR_TWO] = comparator_two;
  assign raw_src[SYN_COMPARATOR_ONE] = comparator_one;
  assign raw_src[SYN_CAP4:SYN_CAP1] = capture_channel_event;
  assign raw_src[SYN_TMR5:SYN_TMR1] = timer_event;

  cssel_sync2 #(
    .W(16)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(raw_src),
    .sync_out(syn_src)
  );

  always @*
  begin
    next_sel = sel;
    if (sync_source_load)
      next_sel = sync_source_select;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sel <= `CSSEL_SEL_RESET;
    else
      sel <= next_sel;
  end

  // Source multiplexer
  always @*
  begin
    next_level = 1'b0;
    case (sel)
      `CSSEL_SRC_OWN: next_level = secondary_compare_match;
      `CSSEL_SRC_IRQ2: next_level = syn_src[SYN_IRQ2];
      `CSSEL_SRC_IRQ1: next_level = syn_src[SYN_IRQ1];
      `CSSEL_SRC_CTU: next_level = syn_src[SYN_CTU];
      `CSSEL_SRC_ADC: next_level = syn_src[SYN_ADC];
      `CSSEL_SRC_COMPARATOR_THREE: next_level = syn_src[SYN_COMPARATOR_THREE];
      `CSSEL_SRC_COMPARATOR_TWO: next_level = syn_src[SYN_COMPARATOR_TWO];
      `CSSEL_SRC_COMPARATOR_ONE: next_level = syn_src[SYN_COMPARATOR_ONE];
      `CSSEL_SRC_CAP1, `CSSEL_SRC_CAP2, `CSSEL_SRC_CAP3, `CSSEL_SRC_CAP4:
        next_level = syn_src[cssel_cap_line(sel[1:0])];
      `CSSEL_SRC_TMR5: next_level = syn_src[SYN_TMR5];
      `CSSEL_SRC_TMR4: next_level = syn_src[SYN_TMR4];
      `CSSEL_SRC_TMR3: next_level = syn_src[SYN_TMR3];
      `CSSEL_SRC_TMR2: next_level = syn_src[SYN_TMR2];
      `CSSEL_SRC_TMR1: next_level = syn_src[SYN_TMR1];
      `CSSEL_SRC_TRIG_GEN: next_level = trigger_gen_output[CHAN_INDEX];
      `CSSEL_SRC_OC1, `CSSEL_SRC_OC2, `CSSEL_SRC_OC3, `CSSEL_SRC_OC4:
        next_level = other_compare_channel[cssel_oc_line(sel[1:0])];
      `CSSEL_SRC_NONE: next_level = 1'b0;
      default: next_level = 1'b0;
    endcase
  end

  always @*
  begin
    next_pulse = next_level & ~prev_level;
  end

  // Deselect before disable is software's duty
  always @*
  begin
    next_trigger_out = enable_d & ~channel_enable;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_level <= 1'b0;
    else
      prev_level <= next_level;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_trigger_pulse <= 1'b0;
    else
      sync_trigger_pulse <= next_pulse;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      enable_d <= 1'b0;
    else
      enable_d <= channel_enable;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      trigger_out <= 1'b0;
    else
      trigger_out <= next_trigger_out;
  end

  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_select_current <= `CSSEL_SEL_RESET;
    else
      sync_select_current <= sel;
  end
endmodule
`default_nettype wire
